/* rtl/ctdr_top.sv */
/*
 * Cable reflectometry diagnostics: control and result registers, the run
 * sequencer over the pair combinations, and the event interrupt.
 * Assumes a same-clock register port with read data one cycle after the
 * read strobe, and an analog front end answering on the same clock.
 */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "ctdr_regs.svh"

// Notes on behaviour
// RULE_01 - Request code 11 runs all ten combinations
// RULE_02 - Request code 10 runs one selected combination
// RULE_03 - Host enables diagnostics, selects mode, enters standby
// RULE_04 - Upper request bit clears when run ends
// RULE_05 - Lower request bit then reports result validity
// RULE_06 - Field reads 11 or 10 while running
// RULE_07 - Send select picks pulse pair A..D
// RULE_08 - Listen select picks echo pair A..D
// RULE_09 - Automatic run ignores both pair selects
// RULE_10 - Distance: chosen pair, or last fault found
// RULE_11 - Automatic order: shorts first, then D,C,B,A
// RULE_12 - No fault found loads distance all ones
// RULE_13 - Distance code is linear in meters
// RULE_14 - Host converts code: minus eight, times 13/16
// RULE_15 - Per-pair two-bit fault type, A uppermost
// RULE_16 - Pair A field holds single-pair result
// RULE_17 - Bits 7..2 flag inter-pair shorts AB..CD
// RULE_18 - Automatic results all present at run end
// RULE_19 - Host polls until in-progress indication clears
module ctdr_top
    import ctdr_pkg::*;
#(
    parameter int TIMEOUT_CYC = `CTDR_ECHO_TIMEOUT_CYC
)(
    // Clock and reset
    input  wire logic           i_ref_clk,
    input  wire logic           i_nrst,

    // Register port
    input  wire logic [5:0]     i_addr,
    input  wire logic [15:0]    i_wdata,
    input  wire logic           i_wr,
    input  wire logic           i_rd,
    output logic [15:0]         o_rdata,

    // Interrupt and status
    output logic                o_irq,
    output logic                o_busy,

    // Analog front end
    output logic                o_pulse_fire,
    output ctdr_pair_type       o_pulse_tx_pair,
    output ctdr_pair_type       o_pulse_rx_pair,
    input  wire logic           i_echo_done,
    input  wire ctdr_fault_type i_echo_type,
    input  wire logic [7:0]     i_echo_range
);

    ctdr_seq_state_type st_r;
    ctdr_seq_state_type st_nxt;

    logic [3:0]         idx_r;
    logic [3:0]         idx_nxt;

    logic [1:0]         req_r;
    logic [1:0]         req_nxt;

    ctdr_pair_type      tx_sel_r;
    ctdr_pair_type      tx_sel_nxt;

    ctdr_pair_type      rx_sel_r;
    ctdr_pair_type      rx_sel_nxt;

    logic [7:0]         dist_r;
    logic [7:0]         dist_nxt;

    logic [15:0]        rslt_r;
    logic [15:0]        rslt_nxt;

    logic               bad_r;
    logic               bad_nxt;

    logic               start_r;
    logic               start_nxt;

    logic [2:0]         prereq_r;

    logic [2:0]         irq_sts_r;
    logic [2:0]         irq_sts_nxt;
    logic [2:0]         irq_en_r;

    logic [2:0]         evt;
    logic               evt_done;
    logic               evt_bad;
    logic               evt_refused;

    // Probe answers
    logic               pr_done;
    logic               pr_ok;
    ctdr_fault_type     pr_type;
    logic [7:0]         pr_range;

    // Address decode
    wire wr_ctrl   = i_wr && (i_addr == `CTDR_ADDR_CTRL);
    wire wr_rslt   = i_wr && (i_addr == `CTDR_ADDR_RSLT);
    wire wr_clr    = i_wr && (i_addr == `CTDR_ADDR_IRQ_CLR);
    wire wr_en     = i_wr && (i_addr == `CTDR_ADDR_IRQ_EN);
    wire wr_prereq = i_wr && (i_addr == `CTDR_ADDR_PREREQ);

    // The run is only meaningful in the documented setup
    wire prereq_ok = prereq_r[`CTDR_PRE_DIAG_EN]
                   & ~prereq_r[`CTDR_PRE_MODE_SEL]
                   & prereq_r[`CTDR_PRE_STANDBY]; // RULE_03

    wire [1:0] wr_req  = i_wdata[`CTDR_REQ_HI:`CTDR_REQ_LO];

    wire       is_auto = req_r[0];
    wire       last    = ~is_auto || (idx_r == (`CTDR_NUM_COMBOS - 4'h1));
    wire       is_short_step = is_auto && (idx_r < `CTDR_NUM_SHORTS);
    wire       is_fault = (pr_type != `CTDR_FAULT_GOOD);

    // Combination table: shorts CD,BD,BC,AD,AC,AB, then pairs D,C,B,A
    // Step 9, pair A, is the default entry
    function automatic logic [3:0] combo(input logic [3:0] i);
        logic [3:0] r;
        r = 4'h0;

        unique case (i)
            4'h0:    r = 4'hB;
            4'h1:    r = 4'h7;
            4'h2:    r = 4'h6;
            4'h3:    r = 4'h3;
            4'h4:    r = 4'h2;
            4'h5:    r = 4'h1;
            4'h6:    r = 4'hF;
            4'h7:    r = 4'hA;
            4'h8:    r = 4'h5;
            default: r = 4'h0;
        endcase

        return r;
    endfunction

    wire [3:0] combo_pairs = combo(idx_r); // RULE_11

    // Selects only steer a single-pair run
    wire ctdr_pair_type probe_tx = is_auto ? combo_pairs[3:2] : tx_sel_r; // RULE_07 RULE_09
    wire ctdr_pair_type probe_rx = is_auto ? combo_pairs[1:0] : rx_sel_r; // RULE_08 RULE_09

    // Result field positions for the current step
    wire [3:0] short_bit = 4'(`CTDR_SHORT_LO) + idx_r; // RULE_17
    wire [1:0] pair_no   = 2'(4'h9 - idx_r);
    wire [3:0] type_lo   = 4'(4'hE - {1'b0, pair_no, 1'b0}); // RULE_15

    // Read side
    wire [15:0] ctrl_view = {req_r, tx_sel_r, rx_sel_r, dist_r, 2'b00};

    wire [15:0] rd_mux =
        (i_addr == `CTDR_ADDR_CTRL)    ? ctrl_view :
        (i_addr == `CTDR_ADDR_RSLT)    ? rslt_r :
        (i_addr == `CTDR_ADDR_IRQ_STS) ? {13'h0000, irq_sts_r} :
        (i_addr == `CTDR_ADDR_IRQ_EN)  ? {13'h0000, irq_en_r} :
        (i_addr == `CTDR_ADDR_PREREQ)  ? {13'h0000, prereq_r} :
                                         16'h0000;

    always_comb begin
        st_nxt      = st_r;
        idx_nxt     = idx_r;
        req_nxt     = req_r;
        tx_sel_nxt  = tx_sel_r;
        rx_sel_nxt  = rx_sel_r;
        dist_nxt    = dist_r;
        rslt_nxt    = rslt_r;
        bad_nxt     = bad_r;
        start_nxt   = 1'b0;
        evt_done    = 1'b0;
        evt_bad     = 1'b0;
        evt_refused = 1'b0;

        unique case (st_r)
            ST_IDLE: begin
                if (wr_rslt) begin
                    rslt_nxt = {i_wdata[15:2], 2'b00};
                end
                if (wr_ctrl) begin
                    req_nxt    = wr_req;
                    tx_sel_nxt = i_wdata[`CTDR_TXSEL_HI:`CTDR_TXSEL_LO];
                    rx_sel_nxt = i_wdata[`CTDR_RXSEL_HI:`CTDR_RXSEL_LO];
                    dist_nxt   = i_wdata[`CTDR_DIST_HI:`CTDR_DIST_LO];
                    if (wr_req[1]) begin
                        // Fresh run: old results are wiped first
                        idx_nxt  = 4'h0;
                        rslt_nxt = `CTDR_RSLT_RST;
                        dist_nxt = `CTDR_DIST_NONE; // RULE_12
                        bad_nxt  = ~prereq_ok;
                        st_nxt   = prereq_ok ? ST_LAUNCH : ST_FINISH; // RULE_01 RULE_02
                    end
                end
            end

            ST_LAUNCH: begin
                start_nxt = 1'b1;
                st_nxt    = ST_WAIT;
            end

            // A timed-out step advances but spoils validity
            ST_WAIT: begin
                if (pr_done) begin
                    if (!pr_ok) begin
                        bad_nxt = 1'b1;
                    end

                    if (!is_auto) begin
                        rslt_nxt[15:14] = pr_type; // RULE_16
                        dist_nxt = is_fault ? pr_range : `CTDR_DIST_NONE; // RULE_10 RULE_12
                    end else begin
                        if (is_short_step) begin
                            rslt_nxt[short_bit] = (pr_type == `CTDR_FAULT_SHORT); // RULE_17
                        end else begin
                            rslt_nxt[type_lo +: 2] = pr_type; // RULE_15 RULE_18
                        end
                        if (is_fault) begin
                            dist_nxt = pr_range; // RULE_10 RULE_13
                        end
                    end

                    if (last) begin
                        st_nxt = ST_FINISH;
                    end else begin
                        idx_nxt = idx_r + 4'h1; // RULE_01 RULE_11
                        st_nxt  = ST_LAUNCH;
                    end
                end
            end

            // Request bit 15 self-clears here
            ST_FINISH: begin
                req_nxt  = {1'b0, ~bad_r}; // RULE_04 RULE_05
                evt_done = 1'b1;
                evt_bad  = bad_r;
                st_nxt   = ST_IDLE;
            end
        endcase

        if (st_r != ST_IDLE) begin
            // Setup lost mid-run spoils the results
            if (!prereq_ok) begin
                bad_nxt = 1'b1;
            end
            // A busy run cannot be restarted or overwritten
            if (wr_ctrl || wr_rslt) begin
                evt_refused = 1'b1;
            end
        end
    end

    assign evt = {evt_refused, evt_bad, evt_done};

    // Hardware set wins over a clear in the same cycle
    assign irq_sts_nxt = (irq_sts_r & ~(wr_clr ? i_wdata[2:0] : 3'h0)) | evt;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r     <= ST_IDLE;
            idx_r    <= 4'h0;
            req_r    <= `CTDR_REQ_INVALID;
            tx_sel_r <= 2'h0;
            rx_sel_r <= 2'h0;
            dist_r   <= 8'h00;
            rslt_r   <= `CTDR_RSLT_RST;
            bad_r    <= 1'b0;
            start_r  <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            idx_r    <= idx_nxt;
            req_r    <= req_nxt; // RULE_06
            tx_sel_r <= tx_sel_nxt;
            rx_sel_r <= rx_sel_nxt;
            dist_r   <= dist_nxt;
            rslt_r   <= rslt_nxt;
            bad_r    <= bad_nxt;
            start_r  <= start_nxt;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prereq_r  <= 3'h0;
            irq_sts_r <= 3'h0;
            irq_en_r  <= 3'h0;
            o_irq     <= 1'b0;
        end else begin
            if (wr_prereq) begin
                prereq_r <= i_wdata[2:0];
            end

            if (wr_en) begin
                irq_en_r <= i_wdata[2:0];
            end

            irq_sts_r <= irq_sts_nxt;
            o_irq     <= |(irq_sts_nxt & (wr_en ? i_wdata[2:0] : irq_en_r));
        end
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 16'h0000;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (st_nxt != ST_IDLE);
        end
    end

    // One measurement in flight at a time
    ctdr_probe #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_probe (
        .i_ref_clk    (i_ref_clk),
        .i_nrst       (i_nrst),
        .i_start      (start_r),
        .i_tx_pair    (probe_tx),
        .i_rx_pair    (probe_rx),
        .o_fire       (o_pulse_fire),
        .o_tx_pair    (o_pulse_tx_pair),
        .o_rx_pair    (o_pulse_rx_pair),
        .i_echo_done  (i_echo_done),
        .i_echo_type  (i_echo_type),
        .i_echo_range (i_echo_range),
        .o_done       (pr_done),
        .o_ok         (pr_ok),
        .o_type       (pr_type),
        .o_range      (pr_range)
    );

endmodule // ctdr_top

/* common/ctdr_regs.svh */
/*
 * Register map, field positions, codes and timing counts of the cable
 * reflectometry diagnostics block.
 * Assumes a 16-bit register port with a 6-bit word address.
 */
`ifndef CTDR_REGS_SVH
`define CTDR_REGS_SVH

`define CTDR_ADDR_CTRL        6'h1E
`define CTDR_ADDR_RSLT        6'h1F
`define CTDR_ADDR_IRQ_STS     6'h20
`define CTDR_ADDR_IRQ_CLR     6'h21
`define CTDR_ADDR_IRQ_EN      6'h22
`define CTDR_ADDR_PREREQ      6'h23

`define CTDR_REQ_HI           15
`define CTDR_REQ_LO           14
`define CTDR_TXSEL_HI         13
`define CTDR_TXSEL_LO         12
`define CTDR_RXSEL_HI         11
`define CTDR_RXSEL_LO         10
`define CTDR_DIST_HI          9
`define CTDR_DIST_LO          2
`define CTDR_SHORT_LO         2

`define CTDR_REQ_AUTO         2'h3
`define CTDR_REQ_SINGLE       2'h2
`define CTDR_REQ_VALID        2'h1
`define CTDR_REQ_INVALID      2'h0

`define CTDR_FAULT_SHORT      2'h3
`define CTDR_FAULT_OPEN       2'h2
`define CTDR_FAULT_MISMATCH   2'h1
`define CTDR_FAULT_GOOD       2'h0

`define CTDR_DIST_NONE        8'hFF
`define CTDR_CTRL_RST         16'h0000
`define CTDR_RSLT_RST         16'h0000

`define CTDR_IRQ_DONE         0
`define CTDR_IRQ_INVALID      1
`define CTDR_IRQ_REFUSED      2

`define CTDR_PRE_DIAG_EN      0
`define CTDR_PRE_MODE_SEL     1
`define CTDR_PRE_STANDBY      2

`define CTDR_NUM_COMBOS       4'hA
`define CTDR_NUM_SHORTS       4'h6
`define CTDR_CLK_PERIOD_NS    25
`define CTDR_ECHO_TIMEOUT_NS  100000
`define CTDR_ECHO_TIMEOUT_CYC (`CTDR_ECHO_TIMEOUT_NS / `CTDR_CLK_PERIOD_NS)

`endif

/* common/ctdr_pkg.sv */
/*
 * Types shared by the reflectometry diagnostics sequencer and probe.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ctdr_pkg;

    typedef logic [1:0] ctdr_pair_type;
    typedef logic [1:0] ctdr_fault_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LAUNCH,
        ST_WAIT,
        ST_FINISH
    } ctdr_seq_state_type;

    typedef enum logic {
        PR_IDLE,
        PR_WAIT
    } ctdr_probe_state_type;

endpackage

/* rtl/ctdr_probe.sv */
/*
 * One reflectometry measurement: fires a pulse on the chosen send pair,
 * then waits for the echo result of the analog front end or a timeout.
 * Assumes the front end answers on the same clock with a one-cycle strobe.
 */
`timescale 1ns/1ps
`include "ctdr_regs.svh"

module ctdr_probe
    import ctdr_pkg::*;
#(
    parameter int TIMEOUT_CYC = `CTDR_ECHO_TIMEOUT_CYC
)(
    // Clock and reset
    input  wire logic          i_ref_clk,
    input  wire logic          i_nrst,
    // Request from sequencer
    input  wire logic          i_start,
    input  wire ctdr_pair_type i_tx_pair,
    input  wire ctdr_pair_type i_rx_pair,
    // Front end
    output logic               o_fire,
    output ctdr_pair_type      o_tx_pair,
    output ctdr_pair_type      o_rx_pair,
    input  wire logic          i_echo_done,
    input  wire ctdr_fault_type i_echo_type,
    input  wire logic [7:0]    i_echo_range,
    // Result
    output logic               o_done,
    output logic               o_ok,
    output ctdr_fault_type     o_type,
    output logic [7:0]         o_range
);

    localparam logic [15:0] TMO_LAST = 16'(TIMEOUT_CYC - 1);

    ctdr_probe_state_type st_r;
    logic [15:0]          tmr_r;

    wire timed_out = (tmr_r == TMO_LAST);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r      <= PR_IDLE;
            tmr_r     <= 16'h0000;
            o_fire    <= 1'b0;
            o_tx_pair <= 2'h0;
            o_rx_pair <= 2'h0;
            o_done    <= 1'b0;
            o_ok      <= 1'b0;
            o_type    <= `CTDR_FAULT_GOOD;
            o_range   <= `CTDR_DIST_NONE;
        end else begin
            o_fire <= 1'b0;
            o_done <= 1'b0;
            unique case (st_r)
                PR_IDLE: begin
                    if (i_start) begin
                        o_fire    <= 1'b1;
                        o_tx_pair <= i_tx_pair;
                        o_rx_pair <= i_rx_pair;
                        tmr_r     <= 16'h0000;
                        st_r      <= PR_WAIT;
                    end
                end
                PR_WAIT: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (i_echo_done) begin
                        o_done  <= 1'b1;
                        o_ok    <= 1'b1;
                        o_type  <= i_echo_type;
                        o_range <= i_echo_range;
                        st_r    <= PR_IDLE;
                    end else if (timed_out) begin
                        // A silent front end yields an invalid, fault-free answer
                        o_done  <= 1'b1;
                        o_ok    <= 1'b0;
                        o_type  <= `CTDR_FAULT_GOOD;
                        o_range <= `CTDR_DIST_NONE;
                        st_r    <= PR_IDLE;
                    end
                end
            endcase
        end
    end

endmodule // ctdr_probe

/* verification/ctdr_monitor.sv */
/*
 * Port-level assertions for the cable reflectometry diagnostics block.
 * Assumes one clock domain and the register map of ctdr_regs.svh.
 */
`timescale 1ns/1ps
`include "ctdr_regs.svh"

module ctdr_monitor
    import ctdr_pkg::*;
#(
    parameter int TIMEOUT_CYC = 8
)(
    // Clock and reset
    input  wire logic           i_ref_clk,
    input  wire logic           i_nrst,
    // Register port
    input  wire logic [5:0]     i_addr,
    input  wire logic [15:0]    i_wdata,
    input  wire logic           i_wr,
    input  wire logic           i_rd,
    input  wire logic [15:0]    o_rdata,
    // Interrupt and status
    input  wire logic           o_irq,
    input  wire logic           o_busy,
    // Analog front end
    input  wire logic           o_pulse_fire,
    input  wire ctdr_pair_type  o_pulse_tx_pair,
    input  wire ctdr_pair_type  o_pulse_rx_pair,
    input  wire logic           i_echo_done,
    input  wire ctdr_fault_type i_echo_type,
    input  wire logic [7:0]     i_echo_range
);
    // Margin covers launch, answer and result hand-over around the echo timeout
    localparam int STEP_MAX = TIMEOUT_CYC + 16;

    logic       auto_r;
    logic [3:0] sel_r;
    logic [3:0] fires_r;
    wire        start_w = i_wr && i_addr == `CTDR_ADDR_CTRL && i_wdata[15] && !o_busy;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            auto_r  <= 1'b0;
            sel_r   <= 4'h0;
            fires_r <= 4'h0;
        end else if (start_w) begin
            auto_r  <= i_wdata[14];
            sel_r   <= i_wdata[13:10];
            fires_r <= 4'h0;
        end else if (o_pulse_fire) begin
            fires_r <= fires_r + 4'h1;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    a_fire_spacing: assert property (o_pulse_fire |=> !o_pulse_fire [*3])
        else $error("pulse fired twice too close");
    a_fire_busy: assert property (o_pulse_fire |-> o_busy)
        else $error("pulse fired while idle");
    a_single_pairs: assert property (o_pulse_fire && !auto_r |->
        {o_pulse_tx_pair, o_pulse_rx_pair} == sel_r)
        else $error("single run used wrong pairs");
    a_auto_ten: assert property ($fell(o_busy) && auto_r && fires_r != 4'h0 |->
        fires_r == `CTDR_NUM_COMBOS)
        else $error("automatic run fire count wrong");
    a_single_one: assert property ($fell(o_busy) && !auto_r && fires_r != 4'h0 |->
        fires_r == 4'h1)
        else $error("single run fire count wrong");
    a_step_bound: assert property (o_pulse_fire |->
        ##[1:STEP_MAX] (o_pulse_fire || !o_busy))
        else $error("measurement step never ended");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (i_rd && i_addr == 6'h3F |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_plain_write: assert property (i_wr && i_addr == `CTDR_ADDR_CTRL && !i_wdata[15] &&
        !o_busy |=> !o_busy)
        else $error("plain control write started a run");
    a_irq_masked: assert property ((i_wr && i_addr == `CTDR_ADDR_IRQ_EN &&
        i_wdata[2:0] == 3'h0) ##1 !i_wr |=> !o_irq)
        else $error("masked interrupt still raised");
endmodule // ctdr_monitor

bind ctdr_top ctdr_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_busy(o_busy),
    .o_pulse_fire(o_pulse_fire), .o_pulse_tx_pair(o_pulse_tx_pair),
    .o_pulse_rx_pair(o_pulse_rx_pair), .i_echo_done(i_echo_done),
    .i_echo_type(i_echo_type), .i_echo_range(i_echo_range));

/* verification/ctdr_cable_model.sv */
/*
 * Behavioural cable and echo front end: answers each pulse from a table unless muted.
 * Assumes the bench fills the tables and the delay before each run.
 */
`timescale 1ns/1ps

module ctdr_cable_model
    import ctdr_pkg::*;
(
    // Clock
    input  wire logic          i_ref_clk,
    // Pulse from the block
    input  wire logic          i_fire,
    input  wire ctdr_pair_type i_tx_pair,
    input  wire ctdr_pair_type i_rx_pair,
    // Echo back
    output logic               o_echo_done,
    output ctdr_fault_type     o_echo_type,
    output logic [7:0]         o_echo_range
);
    ctdr_fault_type fault_tab [16];
    logic [7:0]     range_tab [16];
    logic [3:0]     fired     [$];
    int             delay_cyc;
    bit             mute;
    int             cnt;
    logic [3:0]     key;

    initial begin
        o_echo_done  = 1'b0;
        o_echo_type  = 2'h0;
        o_echo_range = 8'h00;
        delay_cyc    = 2;
        mute         = 1'b0;
        cnt          = -1;
        foreach (fault_tab[i]) begin
            fault_tab[i] = 2'h0;
            range_tab[i] = 8'h00;
        end
    end

    always @(posedge i_ref_clk) begin
        o_echo_done  <= 1'b0;
        // Outside an answer the lines toggle so a stale value is never read as valid
        o_echo_type  <= ~o_echo_type;
        o_echo_range <= ~o_echo_range;
        if (i_fire) begin
            key = {i_tx_pair, i_rx_pair};
            fired.push_back(key);
            cnt = mute ? -1 : delay_cyc;
        end else if (cnt > 0) begin
            cnt = cnt - 1;
        end else if (cnt == 0) begin
            cnt = -1;
            o_echo_done  <= 1'b1;
            o_echo_type  <= fault_tab[key];
            o_echo_range <= range_tab[key];
        end
    end
endmodule // ctdr_cable_model

/* verification/testbench.sv */
/*
 * Self-checking bench for the reflectometry diagnostics block.
 * Assumes the cable model answers pulses and the monitor is bound in.
 */
`timescale 1ns/1ps
`include "ctdr_regs.svh"

module testbench;
    import ctdr_pkg::*;

    logic           i_ref_clk;
    logic           i_nrst;
    logic [5:0]     i_addr;
    logic [15:0]    i_wdata;
    logic           i_wr;
    logic           i_rd;
    logic [15:0]    o_rdata;
    logic           o_irq;
    logic           o_busy;
    logic           o_pulse_fire;
    ctdr_pair_type  o_pulse_tx_pair;
    ctdr_pair_type  o_pulse_rx_pair;
    logic           i_echo_done;
    ctdr_fault_type i_echo_type;
    logic [7:0]     i_echo_range;
    logic [15:0]    d;
    int             n_fail;
    int             check_count;
    logic [3:0]     order [10] = '{4'hB, 4'h7, 4'h6, 4'h3, 4'h2, 4'h1, 4'hF, 4'hA, 4'h5, 4'h0};

    ctdr_top #(.TIMEOUT_CYC(8)) dut (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_busy(o_busy),
        .o_pulse_fire(o_pulse_fire), .o_pulse_tx_pair(o_pulse_tx_pair),
        .o_pulse_rx_pair(o_pulse_rx_pair), .i_echo_done(i_echo_done),
        .i_echo_type(i_echo_type), .i_echo_range(i_echo_range));

    ctdr_cable_model cable (
        .i_ref_clk(i_ref_clk), .i_fire(o_pulse_fire), .i_tx_pair(o_pulse_tx_pair),
        .i_rx_pair(o_pulse_rx_pair), .o_echo_done(i_echo_done),
        .o_echo_type(i_echo_type), .o_echo_range(i_echo_range));

    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] v);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task automatic wait_idle();
        repeat (2) @(posedge i_ref_clk);
        #1;
        for (int i = 0; i < 3000 && o_busy !== 1'b0; i++) begin
            @(posedge i_ref_clk);
            #1;
        end
        if (o_busy !== 1'b0) begin
            n_fail++;
            $display("BAD t=%0t run never ended", $time);
            complete_run();
        end
    endtask

    task automatic t_reset_vals();
        rd(`CTDR_ADDR_CTRL, d); chk(d, `CTDR_CTRL_RST);
        rd(`CTDR_ADDR_RSLT, d); chk(d, `CTDR_RSLT_RST);
        rd(6'h3F, d); chk(d, 16'h0000);
        wr(`CTDR_ADDR_CTRL, 16'h3C00);
        rd(`CTDR_ADDR_CTRL, d); chk(d, 16'h3C00);
    endtask

    task automatic t_no_prereq();
        wr(`CTDR_ADDR_CTRL, 16'hC000);
        wait_idle();
        rd(`CTDR_ADDR_CTRL, d); chk(d[15:14], `CTDR_REQ_INVALID);
        rd(`CTDR_ADDR_IRQ_STS, d); chk(d, 16'h0003);
        wr(`CTDR_ADDR_IRQ_CLR, 16'h0007);
        rd(`CTDR_ADDR_IRQ_CLR, d); chk(d, 16'h0000);
        rd(`CTDR_ADDR_IRQ_STS, d); chk(d, 16'h0000);
    endtask

    task automatic t_single();
        cable.fired.delete();
        cable.delay_cyc = 4;
        cable.fault_tab[4'h9] = `CTDR_FAULT_OPEN;
        cable.range_tab[4'h9] = 8'h40;
        wr(`CTDR_ADDR_PREREQ, 16'h0005);
        wr(`CTDR_ADDR_IRQ_EN, 16'h0001);
        wr(`CTDR_ADDR_CTRL, 16'hA400);
        rd(`CTDR_ADDR_CTRL, d); chk(d[15:14], `CTDR_REQ_SINGLE);
        // Refused while busy: must not disturb the running analysis
        wr(`CTDR_ADDR_CTRL, 16'h0000);
        wait_idle();
        chk(cable.fired.size(), 16'h0001);
        chk(cable.fired[0], 16'h0009);
        rd(`CTDR_ADDR_CTRL, d); chk(d, 16'h6500);
        rd(`CTDR_ADDR_RSLT, d); chk(d, 16'h8000);
        rd(`CTDR_ADDR_IRQ_STS, d); chk(d, 16'h0005);
        chk(o_irq, 16'h0001);
        wr(`CTDR_ADDR_IRQ_EN, 16'h0000);
        @(posedge i_ref_clk);
        #1 chk(o_irq, 16'h0000);
        wr(`CTDR_ADDR_IRQ_CLR, 16'h0007);
    endtask

    task automatic t_none_timeout();
        cable.delay_cyc = 0;
        wr(`CTDR_ADDR_CTRL, 16'hBC00);
        wait_idle();
        rd(`CTDR_ADDR_CTRL, d); chk(d, 16'h7FFC);
        cable.mute = 1'b1;
        wr(`CTDR_ADDR_CTRL, 16'h8000);
        wait_idle();
        cable.mute = 1'b0;
        rd(`CTDR_ADDR_CTRL, d); chk(d[15:14], `CTDR_REQ_INVALID);
        rd(`CTDR_ADDR_IRQ_STS, d); chk(d[1:0], 16'h0003);
    endtask

    task automatic t_auto();
        cable.fired.delete();
        cable.delay_cyc = 1;
        cable.fault_tab[4'hB] = `CTDR_FAULT_SHORT;
        cable.range_tab[4'hB] = 8'h20;
        cable.fault_tab[4'h1] = `CTDR_FAULT_SHORT;
        cable.range_tab[4'h1] = 8'h30;
        cable.fault_tab[4'hF] = `CTDR_FAULT_OPEN;
        cable.range_tab[4'hF] = 8'h50;
        cable.fault_tab[4'h0] = `CTDR_FAULT_MISMATCH;
        cable.range_tab[4'h0] = 8'h11;
        wr(`CTDR_ADDR_CTRL, 16'hFC00);
        rd(`CTDR_ADDR_CTRL, d); chk(d[15:14], `CTDR_REQ_AUTO);
        wait_idle();
        chk(cable.fired.size(), 16'h000A);
        foreach (order[i]) chk(cable.fired[i], order[i]);
        rd(`CTDR_ADDR_CTRL, d); chk(d, 16'h7C44);
        chk(16'((d[9:2] - 8'h08) * 13 / 16), 16'h0007);
        rd(`CTDR_ADDR_RSLT, d); chk(d, 16'h4284);
    endtask

    initial begin
        n_fail      = 0;
        check_count = 0;
        i_nrst      = 1'b0;
        i_addr      = 6'h00;
        i_wdata     = 16'h0000;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        repeat (3) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        t_reset_vals();
        t_no_prereq();
        t_single();
        t_none_timeout();
        t_auto();
        complete_run();
    end
endmodule // testbench
